// ### inc/spp_pkg.sv
// Shared constants and types of the standard PWM generator.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses on aclk.
`default_nettype none
package spp_pkg;
  localparam int NTMR = 3;
  localparam logic [1:0] TSEL_NONE = 2'h3;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DMSB = 8'h04;
  localparam logic [7:0] A_DSHD = 8'h08;
  localparam logic [7:0] A_TSEL = 8'h0C;
  localparam logic [7:0] A_FLAG = 8'h10;
  localparam logic [7:0] A_PDIR = 8'h14;
  localparam logic [7:0] A_TMR0 = 8'h20;
  localparam logic [7:0] A_TMR_END = 8'h50;
  localparam logic [3:0] OFS_PER = 4'h0;
  localparam logic [3:0] OFS_TCON = 4'h4;
  localparam logic [3:0] OFS_CNT = 4'h8;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam int CTRL_PWM_HI = 3;
  localparam int CTRL_PWM_LO = 2;
  localparam logic [1:0] CTRL_PWM_SEL = 2'h3;
  localparam int DLSB_HI = 5;
  localparam int DLSB_LO = 4;
  localparam int TCON_PS_HI = 1;
  localparam int TCON_PS_LO = 0;
  localparam int TCON_RUN = 2;
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [5:0] PRE_END_1 = 6'h03;
  localparam logic [5:0] PRE_END_4 = 6'h0F;
  localparam logic [5:0] PRE_END_16 = 6'h3F;
  localparam logic PDIR_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {logic run; logic [1:0] ps; logic [7:0] per;} spp_tcfg_s;
  typedef struct packed {logic [7:0] cnt; logic [1:0] lo; logic step; logic pend;} spp_tst_s;
  typedef struct packed {logic [7:0] addr; logic [31:0] data; logic [3:0] strb;} spp_wr_s;
endpackage
`default_nettype wire

// ### rtl/spp_timer.sv
// One 8-bit period timer with its prescaler and two-bit time base extension.
// Assumes its configuration comes from registers on the same clock.
`default_nettype none
module spp_timer
  import spp_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration and state.
  input wire spp_tcfg_s cfg,
  output spp_tst_s st
);
  logic [5:0] pre_r;
  logic [7:0] cnt_r;
  logic [5:0] pre_end;
  logic tick;

  // One prescaler counter spans four clock phases times the ratio.
  always_comb begin
    unique case (cfg.ps)
      PS_DIV1: pre_end = PRE_END_1;
      PS_DIV4: pre_end = PRE_END_4;
      default: pre_end = PRE_END_16;
    endcase
  end

  assign tick = cfg.run && (pre_r >= pre_end);
  // There is no postscaler, so only the prescale and period shape the period end.
  assign st.pend = tick && (cnt_r == cfg.per);
  assign st.step = cfg.run && ((pre_r & (pre_end >> 2)) == (pre_end >> 2));
  assign st.cnt = cnt_r;
  assign st.lo = (cfg.ps == PS_DIV1) ? pre_r[1:0] :
                 (cfg.ps == PS_DIV4) ? pre_r[3:2] : pre_r[5:4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= '0;
    end else if (tick) begin
      pre_r <= '0;
    end else if (cfg.run) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || st.pend) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### rtl/spp_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the register file decodes the address and answers reads combinationally.
`default_nettype none
module spp_axil
  import spp_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read channels.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register side.
  output spp_wr_s wr,
  output logic wr_en,
  input wire logic wr_ok,
  input wire logic rd_ok,
  input wire logic [31:0] rd_data
);
  logic aw_r;
  logic w_r;

  // Address and data are held until both are present, in either order.
  assign awready = !aw_r && !bvalid;
  assign wready = !w_r && !bvalid;
  assign arready = !rvalid;
  assign wr_en = aw_r && w_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      wr <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_r <= 1'b1;
        wr.addr <= awaddr;
      end else if (wr_en) begin
        aw_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_r <= 1'b1;
        wr.data <= wdata;
        wr.strb <= wstrb;
      end else if (wr_en) begin
        w_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/spp_pwm.sv
// Standard PWM generator: register file, three period timers and the modulator.
// Assumes an AXI4-Lite master on aclk and a pad that merges pin value and enable.
//
// Functional notes
// - One modulated output pin, 10-bit duty
// - Control register zero releases the pin
// - Two-bit select picks one of three timers
// - Period is (period+1) times four times prescale
// - Period end clears count and sets pin
// - Zero duty never sets the pin
// - Period end copies duty buffer into shadow
// - Postscaler has no effect on period
// - Duty is buffer bits plus control bits 5:4
// - Duty writes never disturb the current period
// - Shadow readable, ignores writes in PWM mode
// - Low duty bits held in two-bit latch
// - Time base low bits: phase or prescaler
// - Time base match with duty clears pin
// - High time is duty times prescale clocks
// - Resolution grows with period, 10 bits max
// - Duty beyond period leaves pin unchanged
// - Prescale ratios 1, 4 and 16
// - Timer sets match flag every period end
`default_nettype none
module spp_pwm
  import spp_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Output pin.
  output logic pwm_output_pin,
  output logic pwm_output_oe
);
  spp_wr_s wr;
  logic wr_en;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic [7:0] ctrl_r;
  logic [7:0] dmsb_r;
  logic [7:0] shadow_r;
  logic [1:0] latch_r;
  logic [1:0] tsel_r;
  logic [NTMR-1:0] flag_r;
  logic pdir_r;
  logic out_r;
  spp_tcfg_s tcfg_r [NTMR];
  spp_tst_s tst [NTMR];
  spp_tst_s sel_st;
  logic pwm_on;
  logic [9:0] duty_new;
  logic [9:0] duty_cur;
  logic [9:0] tbase;
  logic [9:0] tb_inc;
  logic match;
  logic we_ctrl;
  logic we_dmsb;
  logic we_dshd;
  logic we_tsel;
  logic we_flag;
  logic we_pdir;

  function automatic logic is_tmr(input logic [7:0] a);
    return (a >= A_TMR0) && (a < A_TMR_END) && (a[3:0] inside {OFS_PER, OFS_TCON, OFS_CNT});
  endfunction

  function automatic logic [1:0] tmr_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - A_TMR0;
    return d[5:4];
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return is_tmr(a) || (a inside {A_CTRL, A_DMSB, A_DSHD, A_TSEL, A_FLAG, A_PDIR});
  endfunction

  function automatic logic [7:0] wbyte(input logic [7:0] old, input spp_wr_s w);
    return w.strb[0] ? w.data[7:0] : old;
  endfunction

  spp_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr(wr),
    .wr_en(wr_en),
    .wr_ok(wr_ok),
    .rd_ok(rd_ok),
    .rd_data(rd_data)
  );

  assign wr_ok = reg_hit(wr.addr);
  assign rd_ok = reg_hit(araddr);
  assign we_ctrl = wr_en && (wr.addr == A_CTRL);
  assign we_dmsb = wr_en && (wr.addr == A_DMSB);
  assign we_dshd = wr_en && (wr.addr == A_DSHD);
  assign we_tsel = wr_en && (wr.addr == A_TSEL);
  assign we_flag = wr_en && (wr.addr == A_FLAG) && wr.strb[0];
  assign we_pdir = wr_en && (wr.addr == A_PDIR) && wr.strb[0];

  // Duty buffers take writes at any time; only the period end moves them on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= '0;
    end else if (we_ctrl) begin
      ctrl_r <= wbyte(ctrl_r, wr) & CTRL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dmsb_r <= '0;
    end else if (we_dmsb) begin
      dmsb_r <= wbyte(dmsb_r, wr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel_r <= '0;
    end else if (we_tsel && wr.strb[0]) begin
      tsel_r <= wr.data[1:0];
    end
  end

  // Reset leaves the pin an input, as any port is after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pdir_r <= PDIR_RST;
    end else if (we_pdir) begin
      pdir_r <= wr.data[0];
    end
  end

  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    logic we_t;
    assign we_t = wr_en && is_tmr(wr.addr) && (tmr_idx(wr.addr) == 2'(i)) && wr.strb[0];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tcfg_r[i] <= '0;
      end else if (we_t && (wr.addr[3:0] == OFS_PER)) begin
        tcfg_r[i].per <= wr.data[7:0];
      end else if (we_t && (wr.addr[3:0] == OFS_TCON)) begin
        tcfg_r[i].run <= wr.data[TCON_RUN];
        tcfg_r[i].ps <= wr.data[TCON_PS_HI:TCON_PS_LO];
      end
    end

    // A period end in the same cycle as a clear keeps the flag set.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_r[i] <= 1'b0;
      end else if (tst[i].pend) begin
        flag_r[i] <= 1'b1;
      end else if (we_flag && wr.data[i]) begin
        flag_r[i] <= 1'b0;
      end
    end

    spp_timer u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(tcfg_r[i]),
      .st(tst[i])
    );
  end

  // The unused select code freezes the modulator rather than aliasing a timer.
  assign sel_st = (tsel_r != TSEL_NONE) ? tst[tsel_r] : '0;
  assign pwm_on = (ctrl_r[CTRL_PWM_HI:CTRL_PWM_LO] == CTRL_PWM_SEL);
  assign duty_new = {dmsb_r, ctrl_r[DLSB_HI:DLSB_LO]};
  assign duty_cur = {shadow_r, latch_r};
  assign tbase = {sel_st.cnt, sel_st.lo};
  assign tb_inc = tbase + 10'h001;
  // Matching on the next time base value makes the high time exactly duty steps.
  assign match = sel_st.step && !sel_st.pend && (tb_inc == duty_cur);

  // The software-visible write to the shadow address is accepted and dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn || !pwm_on) begin
      shadow_r <= '0;
      latch_r <= '0;
    end else if (sel_st.pend) begin
      shadow_r <= dmsb_r;
      latch_r <= ctrl_r[DLSB_HI:DLSB_LO];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !pwm_on) begin
      out_r <= 1'b0;
    end else if (sel_st.pend) begin
      out_r <= (duty_new != 10'h000);
    end else if (match) begin
      out_r <= 1'b0;
    end
  end

  assign pwm_output_pin = out_r;
  // Mode zero drops the drive at once; the direction bit keeps the pad an input.
  assign pwm_output_oe = pwm_on && !pdir_r;

  always_comb begin
    rd_data = '0;
    if (is_tmr(araddr)) begin
      if (araddr[3:0] == OFS_PER) begin
        rd_data[7:0] = tcfg_r[tmr_idx(araddr)].per;
      end else if (araddr[3:0] == OFS_TCON) begin
        rd_data[TCON_RUN] = tcfg_r[tmr_idx(araddr)].run;
        rd_data[TCON_PS_HI:TCON_PS_LO] = tcfg_r[tmr_idx(araddr)].ps;
      end else begin
        rd_data[7:0] = tst[tmr_idx(araddr)].cnt;
      end
    end else begin
      case (araddr)
        A_CTRL: rd_data[7:0] = ctrl_r;
        A_DMSB: rd_data[7:0] = dmsb_r;
        A_DSHD: rd_data[7:0] = shadow_r;
        A_TSEL: rd_data[1:0] = tsel_r;
        A_FLAG: rd_data[NTMR-1:0] = flag_r;
        A_PDIR: rd_data[0] = pdir_r;
        default: rd_data = '0;
      endcase
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_rel_pin;
    we_ctrl && wr.strb[0] && (wr.data[7:0] == 8'h00) |=> !pwm_output_oe;
  endproperty
  a_rel_pin: assert property (p_rel_pin) else $error("Pin still driven after control cleared.");

  property p_idle_low;
    !pwm_on |=> !pwm_output_pin && (duty_cur == 10'h000);
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("Idle generator not low.");

  property p_start_high;
    pwm_on && sel_st.pend && (duty_new != 10'h000) ##1 pwm_on |-> pwm_output_pin;
  endproperty
  a_start_high: assert property (p_start_high) else $error("Pin not set at period start.");

  property p_zero_duty;
    sel_st.pend && (duty_new == 10'h000) |=> !pwm_output_pin;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("Pin set with zero duty.");

  property p_latch;
    pwm_on && sel_st.pend ##1 pwm_on |-> duty_cur == $past(duty_new);
  endproperty
  a_latch: assert property (p_latch) else $error("Duty not copied at period end.");

  property p_hold_duty;
    pwm_on && !sel_st.pend ##1 pwm_on |-> $stable(duty_cur);
  endproperty
  a_hold_duty: assert property (p_hold_duty) else $error("Duty moved inside a period.");

  property p_shadow_ro;
    we_dshd && pwm_on && !sel_st.pend ##1 pwm_on |-> $stable(shadow_r);
  endproperty
  a_shadow_ro: assert property (p_shadow_ro) else $error("Shadow took a write.");

  property p_match_clear;
    pwm_on && match |=> !pwm_output_pin;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("Pin not cleared on match.");

  property p_no_match;
    pwm_on && !sel_st.pend && !match ##1 pwm_on |-> $stable(pwm_output_pin);
  endproperty
  a_no_match: assert property (p_no_match) else $error("Pin changed without event.");

  property p_flag;
    sel_st.pend |=> flag_r[$past(tsel_r)];
  endproperty
  a_flag: assert property (p_flag) else $error("Match flag not set.");

  c_start: cover property (pwm_on && sel_st.pend && (duty_new != 10'h000));
  c_match: cover property (pwm_on && match ##1 pwm_output_oe);
  c_full: cover property (pwm_on && pwm_output_pin && sel_st.pend && (duty_new > tbase));
  c_release: cover property (pwm_output_oe ##1 !pwm_output_oe);
endmodule
`default_nettype wire

// ### tb/spp_load.sv
// Resistive load on the modulated pin; it measures high time and period.
// Assumes the pin is sampled on aclk and has a pull-down when not driven.
`default_nettype none
module spp_load (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Pin as seen by the load.
  input wire logic pin,
  input wire logic oe,
  // Measurements.
  output logic [31:0] hi_len,
  output logic [31:0] per_len,
  output logic [31:0] run,
  output logic lvl_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  logic [31:0] since_rise;
  // A released pin is pulled low, so a stale value is never seen.
  assign lvl = oe ? pin : 1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_q <= 1'b0;
      since_rise <= 32'h0;
      run <= 32'h0;
      hi_len <= 32'h0;
      per_len <= 32'h0;
    end else begin
      lvl_q <= lvl;
      if (lvl && !lvl_q) begin
        per_len <= since_rise;
        since_rise <= 32'h1;
      end else begin
        since_rise <= since_rise + 32'h1;
      end
      if (!lvl && lvl_q) begin
        hi_len <= run;
      end
      run <= (lvl != lvl_q) ? 32'h1 : run + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench of the PWM generator over its AXI4-Lite registers.
// Assumes the load model measures the pin; no other stimulus source.
`default_nettype none
module tb_top
  import spp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe, lvl_q;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, hi_len, per_len, run, d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  int num_errors = 0, total_checks = 0, cyc = 0;
  int dv [3] = '{1, 4, 16};
  always #4 aclk = ~aclk;
  spp_pwm uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pwm_output_pin(pin), .pwm_output_oe(oe));
  spp_load load (.aclk(aclk), .aresetn(aresetn), .pin(pin), .oe(oe), .hi_len(hi_len),
    .per_len(per_len), .run(run), .lvl_q(lvl_q));
  task automatic end_sim;
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Both halves are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTRL);
    chk(d, 32'h0);
    rd(A_PDIR);
    chk(d, 32'h1);
    rd(A_DSHD);
    chk(d, 32'h0);
    rd(8'hFC);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk({31'h0, oe}, 32'h0);
    wr(A_PDIR, 32'h1);
    wr(A_TMR0 + OFS_PER, 32'h3);
    wr(A_CTRL, 32'h1C);
    chk({31'h0, oe}, 32'h0);
    wr(A_DMSB, 32'h2);
    wr(A_TSEL, 32'h0);
    wr(A_FLAG, 32'h7);
    // Duty 9 over a 16-step period, at each prescale ratio.
    for (int i = 0; i < 3; i++) begin
      wr(A_TMR0 + OFS_TCON, 32'h4 | i);
      repeat (64 * dv[i]) @(posedge aclk);
      rd(A_FLAG);
      chk(d & 32'h1, 32'h1);
      wr(A_FLAG, 32'h7);
      wr(A_PDIR, 32'h0);
      chk({31'h0, oe}, 32'h1);
      repeat (48 * dv[i]) @(posedge aclk);
      chk(per_len, 16 * dv[i]);
      chk(hi_len, 9 * dv[i]);
    end
    rd(A_DSHD);
    chk(d, 32'h2);
    wr(A_DSHD, 32'h55);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(A_DSHD);
    chk(d, 32'h2);
    wr(A_TMR0 + OFS_TCON, 32'h4);
    wr(A_DMSB, 32'h0);
    wr(A_CTRL, 32'h0C);
    repeat (60) @(posedge aclk);
    chk({31'h0, lvl_q}, 32'h0);
    chk(32'(run >= 32), 32'h1);
    wr(A_DMSB, 32'hFF);
    repeat (60) @(posedge aclk);
    chk({31'h0, lvl_q}, 32'h1);
    chk(32'(run >= 32), 32'h1);
    // Second timer with a longer period; timer 0 keeps running at 16.
    wr(A_TMR0 + 8'h10 + OFS_PER, 32'h7);
    wr(A_TMR0 + 8'h10 + OFS_TCON, 32'h4);
    wr(A_DMSB, 32'h1);
    wr(A_CTRL, 32'h1C);
    wr(A_TSEL, 32'h1);
    repeat (100) @(posedge aclk);
    chk(per_len, 32'd32);
    chk(hi_len, 32'd5);
    wr(A_CTRL, 32'h0);
    @(posedge aclk);
    chk({30'h0, oe, pin}, 32'h0);
    rd(A_DSHD);
    chk(d, 32'h0);
    // A mode code with only one of the two PWM bits set must not drive the pin.
    wr(A_CTRL, 32'h1C);
    chk({31'h0, oe}, 32'h1);
    wr(A_CTRL, 32'h18);
    chk({31'h0, oe}, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
